// ---- rtl/dtdf_pkg.sv ----
/*
  Package for the toggle, dither and fault control logic: widths, mode codes,
  field layouts and carrier structs.
  Assumes a single 25 MHz system clock and pins synchronised inside the core.
*/
package dtdf_pkg;

  localparam int CHANNELS  = 8;
  localparam int PINS      = 3;
  localparam int DATA_W    = 16;
  localparam int PINSEL_W  = 2;

  localparam logic [15:0] TRIP_TEMP_C = 16'h00a0;
  localparam int          STRAP_WAIT  = 2;

  typedef enum logic {
    DTDF_MODE_TOGGLE,
    DTDF_MODE_DITHER
  } dtdf_mode_t;

  typedef struct packed {
    logic [DATA_W-1:0] reg_a;
    logic [DATA_W-1:0] reg_b;
    logic [PINSEL_W-1:0] pin_sel;
    logic              enable;
    dtdf_mode_t        mode;
  } dtdf_chan_cfg_t;

  typedef struct packed {
    logic over_temp;
    logic serial_error;
  } dtdf_fault_src_t;

endpackage

// ---- rtl/dtdf_core.sv ----
/*
  Toggle/dither DAC register update, fault indicator and reference start-up.
  Assumes toggle pins, chip select/load and the compensation strap come from
  outside the clock domain; temperature and serial error come from logic on i_sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module dtdf_core #(
  parameter int CHANNELS = dtdf_pkg::CHANNELS,
  parameter int PINS     = dtdf_pkg::PINS,
  parameter int DATA_W   = dtdf_pkg::DATA_W
) (
  input  wire logic                                    i_sys_clk,
  input  wire logic                                    i_reset,
  input  wire logic [PINS-1:0]                         i_toggle_dither_pins,
  input  wire dtdf_pkg::dtdf_chan_cfg_t [CHANNELS-1:0] i_chan_cfg,
  input  wire logic                                    i_chip_select_load,
  input  wire logic                                    i_command_load,
  input  wire logic [DATA_W-1:0]                       i_command_data,
  input  wire logic [2:0]                              i_command_chan,
  input  wire logic [15:0]                             i_junction_temp_c,
  input  wire logic                                    i_serial_error,
  input  wire logic                                    i_standard_compensation_pin,
  input  wire logic                                    i_ext_ref_select,
  output logic [CHANNELS-1:0][DATA_W-1:0]              o_dac_reg,
  output logic [CHANNELS-1:0]                          o_dac_update,
  output logic                                         o_shift_enable,
  output logic                                         o_command_exec,
  output logic                                         o_fault_out,
  output logic                                         o_fault_oe,
  output logic                                         o_fault_active,
  output logic                                         o_int_ref_enable,
  output logic                                         o_ref_drive
);

  // ==========================================================================
  // Derived sizes
  localparam int SEL_W = dtdf_pkg::PINSEL_W;

  // ==========================================================================
  // Toggle pin synchroniser
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] pin_prev;
  logic [PINS-1:0] next_pin_meta;
  logic [PINS-1:0] next_pin_sync;
  logic [PINS-1:0] next_pin_prev;

  always_comb begin
    next_pin_meta = i_toggle_dither_pins;
    next_pin_sync = pin_meta;
    next_pin_prev = pin_sync;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      pin_prev <= next_pin_prev;
    end
  end

  // ==========================================================================
  // Chip select/load synchroniser
  logic csl_meta;
  logic csl_sync;
  logic csl_prev;
  logic next_csl_meta;
  logic next_csl_sync;
  logic next_csl_prev;

  always_comb begin
    next_csl_meta = i_chip_select_load;
    next_csl_sync = csl_meta;
    next_csl_prev = csl_sync;
  end

  // Idle high, so leaving reset gives no false frame end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      csl_meta <= 1'b1;
      csl_sync <= 1'b1;
      csl_prev <= 1'b1;
    end else begin
      csl_meta <= next_csl_meta;
      csl_sync <= next_csl_sync;
      csl_prev <= next_csl_prev;
    end
  end

  // ==========================================================================
  // Compensation strap synchroniser
  logic comp_meta;
  logic comp_sync;
  logic next_comp_meta;
  logic next_comp_sync;

  always_comb begin
    next_comp_meta = i_standard_compensation_pin;
    next_comp_sync = comp_meta;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      comp_meta <= 1'b1;
      comp_sync <= 1'b1;
    end else begin
      comp_meta <= next_comp_meta;
      comp_sync <= next_comp_sync;
    end
  end

  // ==========================================================================
  // Edge detection
  logic [PINS-1:0] pin_rise;
  logic [PINS-1:0] pin_fall;
  logic            csl_rise;

  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;
  assign csl_rise = csl_sync & ~csl_prev;

  // Edge of the selected pin; an unused select reads as no edge
  function automatic logic pick_edge(input logic [PINS-1:0]  edges,
                                     input logic [SEL_W-1:0] sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < PINS; i++) begin
      if (sel == SEL_W'(i)) begin
        hit = edges[i];
      end
    end
    return hit;
  endfunction

  // ==========================================================================
  // Serial framing
  assign o_shift_enable = ~csl_sync;
  assign o_command_exec = csl_rise;

  // ==========================================================================
  // DAC registers
  logic [CHANNELS-1:0][DATA_W-1:0] dac_reg;
  logic [CHANNELS-1:0][DATA_W-1:0] next_dac_reg;
  logic [CHANNELS-1:0]             dac_update;
  logic [CHANNELS-1:0]             next_dac_update;

  // ==========================================================================
  // Channel decode
  logic [CHANNELS-1:0] chan_rise;
  logic [CHANNELS-1:0] chan_fall;
  logic [CHANNELS-1:0] chan_cmd;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_decode
      assign chan_rise[ch] = pick_edge(pin_rise, i_chan_cfg[ch].pin_sel);
      assign chan_fall[ch] = pick_edge(pin_fall, i_chan_cfg[ch].pin_sel);
      assign chan_cmd[ch]  = csl_rise && i_command_load && (int'(i_command_chan) == ch);
    end
  endgenerate

  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_comb begin
        dtdf_pkg::dtdf_chan_cfg_t cfg;
        logic                     rise;
        logic                     fall;
        cfg                 = i_chan_cfg[ch];
        rise                = chan_rise[ch];
        fall                = chan_fall[ch];
        next_dac_reg[ch]    = dac_reg[ch];
        next_dac_update[ch] = 1'b0;
        if (chan_cmd[ch]) begin
          next_dac_reg[ch]    = i_command_data;
          next_dac_update[ch] = 1'b1;
        end else if (cfg.enable) begin
          case (cfg.mode)
            dtdf_pkg::DTDF_MODE_TOGGLE: begin
              if (fall) begin
                next_dac_reg[ch]    = cfg.reg_a;
                next_dac_update[ch] = 1'b1;
              end else if (rise) begin
                next_dac_reg[ch]    = cfg.reg_b;
                next_dac_update[ch] = 1'b1;
              end
            end
            dtdf_pkg::DTDF_MODE_DITHER: begin
              if (rise) begin
                next_dac_reg[ch]    = cfg.reg_b;
                next_dac_update[ch] = 1'b1;
              end
            end
            default: begin
              next_dac_update[ch] = 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      dac_reg    <= '0;
      dac_update <= '0;
    end else begin
      dac_reg    <= next_dac_reg;
      dac_update <= next_dac_update;
    end
  end

  assign o_dac_reg    = dac_reg;
  assign o_dac_update = dac_update;

  // ==========================================================================
  // Fault indicator
  dtdf_pkg::dtdf_fault_src_t fault_src;
  logic                      fault_set;
  logic                      fault;
  logic                      next_fault;

  always_comb begin
    fault_src.over_temp    = i_junction_temp_c > dtdf_pkg::TRIP_TEMP_C;
    fault_src.serial_error = i_serial_error;
    fault_set              = fault_src.over_temp | fault_src.serial_error;
  end

  // A source still present wins over the release
  always_comb begin
    next_fault = fault;
    if (csl_rise) begin
      next_fault = 1'b0;
    end
    if (fault_set) begin
      next_fault = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fault <= 1'b0;
    end else begin
      fault <= next_fault;
    end
  end

  assign o_fault_out    = 1'b0;
  assign o_fault_oe     = fault;
  assign o_fault_active = fault;

  // ==========================================================================
  // Reference start-up
  logic                              strap_taken;
  logic [dtdf_pkg::STRAP_WAIT-1:0]   strap_wait;
  logic                              strap_ready;
  logic                              int_ref_strap;
  logic                              int_ref_enable;
  logic                              next_strap_taken;
  logic [dtdf_pkg::STRAP_WAIT-1:0]   next_strap_wait;
  logic                              next_int_ref_strap;
  logic                              next_int_ref_enable;

  // Strap is taken only once the synchroniser holds post-reset samples
  always_comb begin
    strap_ready         = strap_wait[dtdf_pkg::STRAP_WAIT-1];
    next_strap_wait     = {strap_wait[dtdf_pkg::STRAP_WAIT-2:0], 1'b1};
    next_strap_taken    = strap_taken | strap_ready;
    next_int_ref_strap  = int_ref_strap;
    if (strap_ready && !strap_taken) begin
      next_int_ref_strap = comp_sync;
    end
    next_int_ref_enable = next_strap_taken & next_int_ref_strap & ~i_ext_ref_select;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      strap_taken    <= 1'b0;
      strap_wait     <= '0;
      int_ref_strap  <= 1'b0;
      int_ref_enable <= 1'b0;
    end else begin
      strap_taken    <= next_strap_taken;
      strap_wait     <= next_strap_wait;
      int_ref_strap  <= next_int_ref_strap;
      int_ref_enable <= next_int_ref_enable;
    end
  end

  assign o_int_ref_enable = int_ref_enable;
  assign o_ref_drive      = int_ref_enable;

endmodule

`default_nettype wire

// ---- bench/dtdf_core_monitor.sv ----
/* Port checker for dtdf_core, bound onto every instance.
   Assumes one clock domain with a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module dtdf_core_monitor (
  input wire logic                                                   i_sys_clk,
  input wire logic                                                   i_reset,
  input wire dtdf_pkg::dtdf_chan_cfg_t [dtdf_pkg::CHANNELS-1:0]      i_chan_cfg,
  input wire logic [15:0]                                            i_junction_temp_c,
  input wire logic                                                   i_serial_error,
  input wire logic                                                   i_standard_compensation_pin,
  input wire logic                                                   i_ext_ref_select,
  input wire logic [dtdf_pkg::CHANNELS-1:0]                          o_dac_update,
  input wire logic                                                   o_shift_enable,
  input wire logic                                                   o_command_exec,
  input wire logic                                                   o_fault_out,
  input wire logic                                                   o_fault_oe,
  input wire logic                                                   o_fault_active,
  input wire logic                                                   o_ref_drive,
  input wire logic                                                   o_int_ref_enable
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // ==========================================
  // Fault indicator
  property p_ser; i_serial_error |=> o_fault_oe; endproperty
  a_ser: assert property (p_ser) else $error("serial error not flagged");
  property p_hot; i_junction_temp_c > dtdf_pkg::TRIP_TEMP_C |=> o_fault_oe; endproperty
  a_hot: assert property (p_hot) else $error("over temperature not flagged");
  property p_pin; !o_fault_out && (o_fault_active == o_fault_oe); endproperty
  a_pin: assert property (p_pin) else $error("fault pin drive wrong");
  property p_rel; $fell(o_fault_oe) |-> $past(o_command_exec); endproperty
  a_rel: assert property (p_rel) else $error("fault released without frame end");
  // ==========================================
  // Frame end, channel updates, reference
  property p_exe; o_command_exec |-> $past(o_shift_enable) && !o_shift_enable ##1 !o_command_exec;
  endproperty
  a_exe: assert property (p_exe) else $error("command execute misplaced");
  property p_off; (!i_chan_cfg[0].enable && !o_command_exec) [*4] |=> !o_dac_update[0]; endproperty
  a_off: assert property (p_off) else $error("disabled channel updated");
  property p_upd; |o_dac_update |=> ~|o_dac_update; endproperty
  a_upd: assert property (p_upd) else $error("update pulse too long");
  property p_ext; i_ext_ref_select [*2] |-> !o_ref_drive; endproperty
  a_ext: assert property (p_ext) else $error("reference driven in external mode");
  property p_strap; !i_standard_compensation_pin [*8] |-> !o_int_ref_enable; endproperty
  a_strap: assert property (p_strap) else $error("internal reference on with strap low");
  c_rel: cover property ($fell(o_fault_oe));
  c_upd: cover property (|o_dac_update);
  c_exe: cover property (o_command_exec);
endmodule
bind dtdf_core dtdf_core_monitor u_mon (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_chan_cfg(i_chan_cfg),
  .i_junction_temp_c(i_junction_temp_c), .i_serial_error(i_serial_error),
  .i_standard_compensation_pin(i_standard_compensation_pin), .i_ext_ref_select(i_ext_ref_select),
  .o_dac_update(o_dac_update), .o_shift_enable(o_shift_enable), .o_command_exec(o_command_exec),
  .o_fault_out(o_fault_out), .o_fault_oe(o_fault_oe), .o_fault_active(o_fault_active),
  .o_ref_drive(o_ref_drive), .o_int_ref_enable(o_int_ref_enable));
`default_nettype wire

// ---- bench/dtdf_host.sv ----
/* Host model: drives the toggle pins and chip select/load.
   Assumes the bench calls its tasks; changes land at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module dtdf_host (
  input  wire logic                        i_sys_clk,
  output logic [dtdf_pkg::PINS-1:0]        o_pins,
  output logic                             o_csl
);
  initial begin
    o_pins = '0;
    o_csl  = 1'b1;
  end
  // ==========================================
  // Pin edge, then held for one 320 ns link period
  task automatic pin(input int p, input logic v);
    @(negedge i_sys_clk);
    o_pins[p] = v;
    repeat (8) @(negedge i_sys_clk);
  endtask
  task automatic frame();
    @(negedge i_sys_clk);
    o_csl = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    o_csl = 1'b1;
    repeat (4) @(negedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
/* Self-checking bench for dtdf_core with a host model.
   Assumes a 25 MHz clock and inputs driven at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                                       clk = 1'b0, rst = 1'b1, cload = 1'b0, serr = 1'b0;
  logic                                       strap = 1'b0, ext = 1'b0, csl, v, foe, iref, rdrv;
  logic [15:0]                                temp = 16'h0019, cdata = 16'h0000;
  logic [2:0]                                 cchan = 3'h0, pins;
  dtdf_pkg::dtdf_chan_cfg_t [7:0]             cfg = '0;
  logic [7:0][15:0]                           dac, exp_dac;
  int                                         n_fail = 0, comparisons = 0, p;
  always #20 clk = ~clk;
  dtdf_host u_dtdf_host (.i_sys_clk(clk), .o_pins(pins), .o_csl(csl));
  dtdf_core u_dtdf_core (.i_sys_clk(clk), .i_reset(rst), .i_toggle_dither_pins(pins),
    .i_chan_cfg(cfg), .i_chip_select_load(csl), .i_command_load(cload),
    .i_command_data(cdata), .i_command_chan(cchan), .i_junction_temp_c(temp),
    .i_serial_error(serr), .i_standard_compensation_pin(strap), .i_ext_ref_select(ext),
    .o_dac_reg(dac), .o_dac_update(), .o_shift_enable(), .o_command_exec(),
    .o_fault_out(), .o_fault_oe(foe), .o_fault_active(), .o_int_ref_enable(iref),
    .o_ref_drive(rdrv));
  // ==========================================
  // Checking helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [15:0] nxt(input dtdf_pkg::dtdf_chan_cfg_t c, input int p,
                                      input logic r, input logic [15:0] o);
    if (!c.enable || c.pin_sel != 2'(p)) return o;
    if (r) return c.reg_b;
    return (c.mode == dtdf_pkg::DTDF_MODE_TOGGLE) ? c.reg_a : o;
  endfunction
  task automatic restart(input logic s);
    @(negedge clk);
    rst = 1'b1;
    strap = s;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h25a4));
    restart(1'b0);
    chk({15'h0, iref}, 16'h0000);
    restart(1'b1);
    chk({15'h0, rdrv}, 16'h0001);
    ext = 1'b1;
    repeat (3) @(negedge clk);
    chk({15'h0, rdrv}, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      cfg[c].reg_a = 16'($urandom);
      cfg[c].reg_b = 16'($urandom);
      cfg[c].pin_sel = 2'($urandom % 3);
      cfg[c].enable = 1'($urandom);
      cfg[c].mode = dtdf_pkg::dtdf_mode_t'(1'($urandom));
      exp_dac[c] = 16'h0000;
    end
    cfg[0].enable = 1'b0;
    cfg[1].enable = 1'b1;
    cfg[1].mode = dtdf_pkg::DTDF_MODE_DITHER;
    for (int i = 0; i < 14; i++) begin
      p = (i < 6) ? i % 3 : $urandom % 3;
      v = ~pins[p];
      u_dtdf_host.pin(p, v);
      for (int c = 0; c < 8; c++) begin
        exp_dac[c] = nxt(cfg[c], p, v, exp_dac[c]);
        chk(dac[c], exp_dac[c]);
      end
    end
    cchan = 3'($urandom);
    cdata = 16'($urandom);
    cload = 1'b1;
    u_dtdf_host.frame();
    cload = 1'b0;
    chk(dac[cchan], cdata);
    serr = 1'b1;
    @(negedge clk) serr = 1'b0;
    repeat (3) @(negedge clk);
    chk({15'h0, foe}, 16'h0001);
    u_dtdf_host.frame();
    chk({15'h0, foe}, 16'h0000);
    temp = 16'h00a1;
    repeat (3) @(negedge clk);
    chk({15'h0, foe}, 16'h0001);
    temp = 16'h00a0;
    u_dtdf_host.frame();
    repeat (3) @(negedge clk);
    chk({15'h0, foe}, 16'h0000);
    conclude();
  end
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
